//--- rtl/capture_pkg.sv
// shared types and constants of the camera capture front end
package capture_pkg;

  // ----------------------------------------------------------------
  // timing reference code detection
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_ONES_WORD  = 8'hff;
  localparam logic [7:0] CODE_ZERO_WORD  = 8'h00;
  localparam logic [7:0] CODE_MATCH_MASK = 8'hfc;
  localparam int         CODE_MARK_BIT   = 7;
  localparam int         FIELD_BIT       = 6;
  localparam int         BLANK_BIT       = 5;
  localparam int         EDGE_BIT        = 4;
  localparam int         PROT_HI_BIT     = 3;
  localparam int         PROT_LO_BIT     = 0;
  localparam logic       EDGE_IS_START   = 1'b0;

  typedef enum logic [3:0] {
    HUNT      = 4'h1,
    GOT_ONES  = 4'h2,
    GOT_ZERO1 = 4'h4,
    GOT_ZERO2 = 4'h8
  } code_state_t;

  // ----------------------------------------------------------------
  // samples and bus words
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_Y  = 2'h0,
    KIND_CB = 2'h1,
    KIND_CR = 2'h2
  } kind_t;

  localparam int PLANES     = 3;
  localparam int BYTE_LANES = 4;

  typedef struct packed {
    kind_t      kind;
    logic       odd_line;
    logic [7:0] value;
  } sample_t;

  typedef struct packed {
    logic [1:0]  bank;
    logic [1:0]  plane;
    logic [31:0] data;
  } bus_word_t;

  typedef struct packed {
    logic global_en;
    logic codec_en;
    logic preview_en;
    logic fmt_420;
    logic rgb24;
  } capture_cfg_t;

  localparam logic [7:0] PAD_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // colour conversion, 8 fractional bits
  // ----------------------------------------------------------------
  localparam logic signed [19:0] CHROMA_BIAS = 20'sh00080;
  localparam logic signed [19:0] CR_TO_R     = 20'sh00167;
  localparam logic signed [19:0] CB_TO_G     = 20'sh00058;
  localparam logic signed [19:0] CR_TO_G     = 20'sh000b7;
  localparam logic signed [19:0] CB_TO_B     = 20'sh001c6;
  localparam int                 COEF_SHIFT  = 8;
  localparam logic signed [19:0] LEVEL_MAX   = 20'sh000ff;

endpackage : capture_pkg

//--- rtl/capture_front_end.sv
// camera capture front end: sync decode, clock crossing, path packing
// What this block does
// - recognise start and end timing codes
// - code is FF,00,00 then fourth word
// - fourth word: mark, field, blank, edge, protection
// - ignore two low bits of code words
// - field 0/1, blanking 1, start 0 end 1
// - two independent bus-facing capture paths
// - preview path writes RGB pixels
// - codec path writes YCbCr 4:2:0 or 4:2:2
// - each path disabled independently
// - pixel clock and system clock domains
// - four ping-pong banks, codec Y/Cb/Cr planes
// - codec words little-endian, earliest byte low
// - RGB24 one pixel, RGB16 two per word
// - commands take effect at frame sync fall
// - frame sync level readable as status
// - preview without codec overflows codec input
// - frame interrupt before capture, last at end
// - last-frame interrupt enable clears itself
// - frame counter steps per interrupt, 0 to 3
// - mode bit 0 embedded, 1 separate sync
// - polarity bits invert clock and syncs
`timescale 1ns/100ps
module capture_front_end #(
  parameter int FIFO_DEPTH_LOG2 = 4
) (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  cam_pixel_clock_in,
  input  wire logic [7:0]            pixel_bus_in,
  input  wire logic                  frame_sync_in,
  input  wire logic                  line_valid_in,
  input  wire logic                  sync_mode_select,
  input  wire logic                  invert_pixel_clock,
  input  wire logic                  invert_frame_sync,
  input  wire logic                  invert_line_sync,
  input  wire logic                  capture_enable_global,
  input  wire logic                  capture_enable_codec_scaler,
  input  wire logic                  capture_enable_preview_scaler,
  input  wire logic                  codec_format_420,
  input  wire logic                  preview_rgb24,
  input  wire logic                  final_frame_irq_arm,
  input  wire logic                  soft_reset_bit,
  input  wire logic                  clear_codec_overflow,
  input  wire logic                  codec_word_ready,
  input  wire logic                  preview_word_ready,
  output logic                       codec_word_valid,
  output capture_pkg::bus_word_t     codec_word,
  output logic                       preview_word_valid,
  output capture_pkg::bus_word_t     preview_word,
  output logic                       frame_irq,
  output logic [1:0]                 frame_counter,
  output logic                       frame_sync_status,
  output logic                       final_frame_irq_enable,
  output logic                       codec_overflow,
  output logic                       field_status,
  output logic                       blanking_status
);

  localparam int DEPTH = 1 << FIFO_DEPTH_LOG2;
  localparam int PW    = FIFO_DEPTH_LOG2 + 1;

  // ----------------------------------------------------------------
  // reset and configuration toward the pixel domain
  // ----------------------------------------------------------------
  logic       rst_all;
  logic       rst_req;
  logic       px_rst_meta;
  logic       px_rst;
  logic [2:0] pin_cfg_meta;
  logic [2:0] pin_cfg_px;
  logic       any_meta;
  logic       any_px;
  logic       any_active;

  assign rst_all = reset | soft_reset_bit;

  always_ff @(posedge ref_clk) begin
    rst_req <= rst_all;
  end

  always_ff @(posedge cam_pixel_clock_in) begin
    px_rst_meta  <= rst_req;
    px_rst       <= px_rst_meta;
    pin_cfg_meta <= {sync_mode_select, invert_pixel_clock, invert_line_sync};
    pin_cfg_px   <= pin_cfg_meta;
    any_meta     <= any_active;
    any_px       <= any_meta;
  end

  // ----------------------------------------------------------------
  // pin sampling on either pixel clock edge
  // ----------------------------------------------------------------
  // the clock itself is never inverted; both edges are sampled and one
  // is picked, which keeps the clock tree free of logic
  logic [8:0] pos_a;
  logic [8:0] neg_a;
  logic [8:0] pos_b;
  logic [8:0] neg_b;
  logic [8:0] pins_px;

  always_ff @(negedge cam_pixel_clock_in) begin
    neg_a <= {pixel_bus_in, line_valid_in};
  end

  always_ff @(posedge cam_pixel_clock_in) begin
    pos_a   <= {pixel_bus_in, line_valid_in};
    pos_b   <= pos_a;
    neg_b   <= neg_a;
    pins_px <= pin_cfg_px[1] ? neg_b : pos_b;
  end

  logic [7:0] pix;
  logic       line_now;
  logic       line_prev;
  logic       sep_mode;

  assign pix      = pins_px[8:1];
  assign line_now = pins_px[0] ^ pin_cfg_px[0];
  assign sep_mode = pin_cfg_px[2];

  // ----------------------------------------------------------------
  // embedded timing code detection
  // ----------------------------------------------------------------
  capture_pkg::code_state_t code_state;
  capture_pkg::code_state_t next_code_state;
  logic is_ones;
  logic is_zero;
  logic code_hit;
  logic in_active;
  logic field_px;
  logic blank_px;
  logic [3:0] protect_px;

  assign is_ones = (pix & capture_pkg::CODE_MATCH_MASK)
                == (capture_pkg::CODE_ONES_WORD & capture_pkg::CODE_MATCH_MASK);
  assign is_zero = (pix & capture_pkg::CODE_MATCH_MASK)
                == (capture_pkg::CODE_ZERO_WORD & capture_pkg::CODE_MATCH_MASK);
  assign code_hit = (code_state == capture_pkg::GOT_ZERO2)
                 && pix[capture_pkg::CODE_MARK_BIT];

  always_comb begin
    case (code_state)
      capture_pkg::HUNT: begin
        next_code_state = is_ones ? capture_pkg::GOT_ONES : capture_pkg::HUNT;
      end
      capture_pkg::GOT_ONES: begin
        if (is_zero) next_code_state = capture_pkg::GOT_ZERO1;
        else if (is_ones) next_code_state = capture_pkg::GOT_ONES;
        else next_code_state = capture_pkg::HUNT;
      end
      capture_pkg::GOT_ZERO1: begin
        if (is_zero) next_code_state = capture_pkg::GOT_ZERO2;
        else if (is_ones) next_code_state = capture_pkg::GOT_ONES;
        else next_code_state = capture_pkg::HUNT;
      end
      capture_pkg::GOT_ZERO2: begin
        next_code_state = capture_pkg::HUNT;
      end
      default: begin
        next_code_state = capture_pkg::HUNT;
      end
    endcase
  end

  always_ff @(posedge cam_pixel_clock_in) begin
    if (px_rst || sep_mode) begin
      code_state <= capture_pkg::HUNT;
    end else begin
      code_state <= next_code_state;
    end
  end

  always_ff @(posedge cam_pixel_clock_in) begin
    if (px_rst) begin
      in_active  <= 1'b0;
      field_px   <= 1'b0;
      blank_px   <= 1'b0;
      protect_px <= 4'h0;
    end else if (code_hit) begin
      field_px   <= pix[capture_pkg::FIELD_BIT];
      blank_px   <= pix[capture_pkg::BLANK_BIT];
      protect_px <= pix[capture_pkg::PROT_HI_BIT:capture_pkg::PROT_LO_BIT];
      in_active  <= (pix[capture_pkg::EDGE_BIT] == capture_pkg::EDGE_IS_START)
                 && !pix[capture_pkg::BLANK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // sample sequencing in the pixel domain
  // ----------------------------------------------------------------
  logic       line_start;
  logic       in_line;
  logic       byte_ok;
  logic       take_px;
  logic [1:0] phase;
  logic       odd_line;
  capture_pkg::sample_t wr_sample;

  assign line_start = sep_mode ? (line_now && !line_prev)
                    : (code_hit && pix[capture_pkg::EDGE_BIT]
                       == capture_pkg::EDGE_IS_START);
  assign in_line = sep_mode ? line_now : in_active;
  // reserved code bytes never carry video in embedded mode
  assign byte_ok = sep_mode || !(is_ones || is_zero);
  assign take_px = in_line && byte_ok && any_px && !code_hit;

  always_ff @(posedge cam_pixel_clock_in) begin
    if (px_rst) begin
      line_prev <= 1'b0;
      phase     <= 2'h0;
      odd_line  <= 1'b0;
    end else begin
      line_prev <= line_now;
      if (line_start) odd_line <= !odd_line;
      if (take_px) phase <= phase + 2'h1;
      else if (!in_line) phase <= 2'h0;
    end
  end

  always_comb begin
    wr_sample.value    = pix;
    wr_sample.odd_line = odd_line;
    if (!phase[0]) wr_sample.kind = capture_pkg::KIND_Y;
    else if (phase[1]) wr_sample.kind = capture_pkg::KIND_CR;
    else wr_sample.kind = capture_pkg::KIND_CB;
  end

  // ----------------------------------------------------------------
  // asynchronous sample fifo, gray pointers
  // ----------------------------------------------------------------
  capture_pkg::sample_t mem [DEPTH];
  logic [PW-1:0] wbin;
  logic [PW-1:0] wgray;
  logic [PW-1:0] rgray_meta;
  logic [PW-1:0] rgray_px;
  logic [PW-1:0] rbin;
  logic [PW-1:0] rgray;
  logic [PW-1:0] wgray_meta;
  logic [PW-1:0] wgray_sys;
  logic [PW-1:0] next_wbin;
  logic [PW-1:0] next_rbin;
  logic          full;
  logic          empty;
  logic          overflow_toggle;
  logic          pop;

  assign next_wbin = wbin + PW'(1);
  assign next_rbin = rbin + PW'(1);
  assign full  = wgray == {~rgray_px[PW-1:PW-2], rgray_px[PW-3:0]};
  assign empty = rgray == wgray_sys;

  always_ff @(posedge cam_pixel_clock_in) begin
    rgray_meta <= rgray;
    rgray_px   <= rgray_meta;
  end

  always_ff @(posedge cam_pixel_clock_in) begin
    if (px_rst) begin
      wbin            <= '0;
      wgray           <= '0;
      overflow_toggle <= 1'b0;
    end else if (take_px) begin
      if (!full) begin
        mem[wbin[PW-2:0]] <= wr_sample;
        wbin              <= next_wbin;
        wgray             <= next_wbin ^ (next_wbin >> 1);
      end else begin
        overflow_toggle <= !overflow_toggle;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    wgray_meta <= wgray;
    wgray_sys  <= wgray_meta;
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      rbin  <= '0;
      rgray <= '0;
    end else if (pop) begin
      rbin  <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
    end
  end

  // ----------------------------------------------------------------
  // status crossing into the system domain
  // ----------------------------------------------------------------
  logic [3:0] stat_meta;
  logic [3:0] stat_sys;
  logic       ov_seen;
  logic       fs_level;
  logic       fs_prev;
  logic       fs_fall;

  always_ff @(posedge ref_clk) begin
    stat_meta <= {frame_sync_in, blank_px, field_px, overflow_toggle};
    stat_sys  <= stat_meta;
  end

  assign fs_level = sync_mode_select ? (stat_sys[3] ^ invert_frame_sync)
                  : stat_sys[2];
  assign fs_fall  = fs_prev && !fs_level;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fs_prev           <= 1'b0;
      frame_sync_status <= 1'b0;
      field_status      <= 1'b0;
      blanking_status   <= 1'b0;
      ov_seen           <= 1'b0;
    end else begin
      fs_prev           <= fs_level;
      frame_sync_status <= fs_level;
      field_status      <= stat_sys[1];
      blanking_status   <= stat_sys[2];
      ov_seen           <= stat_sys[0];
    end
  end

  // ----------------------------------------------------------------
  // commands, frame interrupt and frame counter
  // ----------------------------------------------------------------
  capture_pkg::capture_cfg_t act;
  logic       new_on;
  logic       last_fire;
  logic [1:0] bank;

  assign new_on = capture_enable_global
               && (capture_enable_codec_scaler || capture_enable_preview_scaler);
  assign last_fire = fs_fall && !new_on && act.global_en
                  && final_frame_irq_enable;
  assign any_active = act.global_en && (act.codec_en || act.preview_en);

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      act <= '0;
    end else if (fs_fall) begin
      act.global_en  <= capture_enable_global;
      act.codec_en   <= capture_enable_codec_scaler;
      act.preview_en <= capture_enable_preview_scaler;
      act.fmt_420    <= codec_format_420;
      act.rgb24      <= preview_rgb24;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      frame_irq     <= 1'b0;
      frame_counter <= 2'h0;
      bank          <= 2'h0;
    end else begin
      frame_irq <= 1'b0;
      if (fs_fall && new_on) begin
        frame_irq     <= 1'b1;
        bank          <= frame_counter;
        frame_counter <= frame_counter + 2'h1;
      end else if (last_fire) begin
        frame_irq     <= 1'b1;
        frame_counter <= frame_counter + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      final_frame_irq_enable <= 1'b0;
    end else if (final_frame_irq_arm) begin
      final_frame_irq_enable <= 1'b1;
    end else if (last_fire) begin
      final_frame_irq_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fifo drain and codec overflow flag
  // ----------------------------------------------------------------
  capture_pkg::sample_t rd_sample;
  logic codec_on;
  logic preview_on;
  logic preview_pending;
  logic stall;
  logic ov_event;

  assign rd_sample  = mem[rbin[PW-2:0]];
  assign codec_on   = act.global_en && act.codec_en;
  assign preview_on = act.global_en && act.preview_en;
  assign stall = (codec_word_valid && !codec_word_ready)
              || (preview_word_valid && !preview_word_ready)
              || preview_pending;
  assign pop = !empty && !stall;
  assign ov_event = (ov_seen != stat_sys[0])
                 || (pop && preview_on && !codec_on);

  // survives soft reset so software can see and clear it afterwards
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      codec_overflow <= 1'b0;
    end else if (ov_event) begin
      codec_overflow <= 1'b1;
    end else if (clear_codec_overflow) begin
      codec_overflow <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // codec path: per-plane little-endian packing
  // ----------------------------------------------------------------
  logic [31:0] codec_acc   [capture_pkg::PLANES];
  logic [1:0]  codec_count [capture_pkg::PLANES];
  logic [1:0]  sel;
  logic        codec_take;
  logic [31:0] next_codec_acc;

  assign sel = rd_sample.kind;
  assign codec_take = pop && codec_on
    && (rd_sample.kind == capture_pkg::KIND_Y
        || !(act.fmt_420 && rd_sample.odd_line));

  always_comb begin
    next_codec_acc = codec_acc[sel];
    next_codec_acc[{codec_count[sel], 3'b000} +: 8] = rd_sample.value;
  end

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      codec_word_valid <= 1'b0;
      codec_word       <= '0;
      for (int i = 0; i < capture_pkg::PLANES; i++) begin
        codec_acc[i]   <= '0;
        codec_count[i] <= 2'h0;
      end
    end else begin
      if (codec_word_valid && codec_word_ready) codec_word_valid <= 1'b0;
      if (codec_take) begin
        codec_acc[sel]   <= next_codec_acc;
        codec_count[sel] <= codec_count[sel] + 2'h1;
        if (codec_count[sel] == 2'(capture_pkg::BYTE_LANES - 1)) begin
          codec_word_valid <= 1'b1;
          codec_word.bank  <= bank;
          codec_word.plane <= sel;
          codec_word.data  <= next_codec_acc;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // preview path: colour conversion and RGB packing
  // ----------------------------------------------------------------
  function automatic logic [7:0] clamp(input logic signed [19:0] v);
    if (v < 0) return 8'h00;
    if (v > capture_pkg::LEVEL_MAX) return 8'hff;
    return v[7:0];
  endfunction : clamp

  function automatic logic [23:0] to_rgb(input logic [7:0] y,
                                         input logic [7:0] cb,
                                         input logic [7:0] cr);
    logic signed [19:0] dy;
    logic signed [19:0] dcb;
    logic signed [19:0] dcr;
    logic signed [19:0] r;
    logic signed [19:0] g;
    logic signed [19:0] b;
    dy  = signed'({12'h000, y});
    dcb = signed'({12'h000, cb}) - capture_pkg::CHROMA_BIAS;
    dcr = signed'({12'h000, cr}) - capture_pkg::CHROMA_BIAS;
    r = dy + ((dcr * capture_pkg::CR_TO_R) >>> capture_pkg::COEF_SHIFT);
    g = dy - ((dcb * capture_pkg::CB_TO_G + dcr * capture_pkg::CR_TO_G)
              >>> capture_pkg::COEF_SHIFT);
    b = dy + ((dcb * capture_pkg::CB_TO_B) >>> capture_pkg::COEF_SHIFT);
    return {clamp(r), clamp(g), clamp(b)};
  endfunction : to_rgb

  function automatic logic [15:0] to_565(input logic [23:0] p);
    return {p[23:19], p[15:10], p[7:3]};
  endfunction : to_565

  logic [7:0]  y0;
  logic [7:0]  y1;
  logic [7:0]  cb;
  logic        have_y0;
  logic [23:0] pix0;
  logic [23:0] pix1;
  logic [23:0] held_pix;

  assign pix0 = to_rgb(y0, cb, rd_sample.value);
  assign pix1 = to_rgb(y1, cb, rd_sample.value);

  always_ff @(posedge ref_clk) begin
    if (rst_all) begin
      y0                 <= 8'h00;
      y1                 <= 8'h00;
      cb                 <= 8'h00;
      have_y0            <= 1'b0;
      held_pix           <= '0;
      preview_pending    <= 1'b0;
      preview_word_valid <= 1'b0;
      preview_word       <= '0;
    end else begin
      if (preview_word_valid && preview_word_ready) begin
        preview_word_valid <= 1'b0;
      end
      // second RGB24 pixel goes out once the word slot is free
      if (preview_pending && !preview_word_valid) begin
        preview_pending         <= 1'b0;
        preview_word_valid      <= 1'b1;
        preview_word.data       <= {capture_pkg::PAD_BYTE, held_pix};
      end
      if (pop && preview_on) begin
        case (rd_sample.kind)
          capture_pkg::KIND_Y: begin
            if (!have_y0) y0 <= rd_sample.value;
            else y1 <= rd_sample.value;
            have_y0 <= !have_y0;
          end
          capture_pkg::KIND_CB: begin
            cb <= rd_sample.value;
          end
          capture_pkg::KIND_CR: begin
            have_y0            <= 1'b0;
            preview_word_valid <= 1'b1;
            preview_word.bank  <= bank;
            preview_word.plane <= capture_pkg::KIND_Y;
            if (act.rgb24) begin
              preview_word.data <= {capture_pkg::PAD_BYTE, pix0};
              held_pix          <= pix1;
              preview_pending   <= 1'b1;
            end else begin
              preview_word.data <= {to_565(pix1), to_565(pix0)};
            end
          end
          default: begin
            have_y0 <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : capture_front_end

//--- tb/capture_front_end_chk.sv
// port assertions for the capture front end
`timescale 1ns/100ps
module capture_front_end_chk (
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       frame_irq,
  input wire logic [1:0] frame_counter,
  input wire logic       final_frame_irq_arm,
  input wire logic       final_frame_irq_enable,
  input wire logic       sync_mode_select,
  input wire logic       frame_sync_in,
  input wire logic       invert_frame_sync,
  input wire logic       frame_sync_status,
  input wire logic       soft_reset_bit,
  input wire logic       codec_word_valid,
  input wire logic       codec_word_ready,
  input wire capture_pkg::bus_word_t codec_word,
  input wire logic       codec_overflow,
  input wire logic       clear_codec_overflow
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_irq_one; frame_irq |=> !frame_irq; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq wide");
  property p_cnt; frame_irq |-> frame_counter == $past(frame_counter) + 2'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_hold; !frame_irq && !$past(soft_reset_bit) |-> $stable(frame_counter);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_arm; final_frame_irq_arm |=> final_frame_irq_enable; endproperty
  a_arm: assert property (p_arm) else $error("arm lost");
  property p_clr; $fell(final_frame_irq_enable) && !$past(soft_reset_bit)
    |-> frame_irq || $past(frame_irq); endproperty
  a_clr: assert property (p_clr) else $error("enable cleared alone");
  property p_sync; (sync_mode_select && (frame_sync_in ^ invert_frame_sync)) [*5]
    |-> frame_sync_status; endproperty
  a_sync: assert property (p_sync) else $error("sync status");
  property p_stall; codec_word_valid && !codec_word_ready && !soft_reset_bit
    |=> codec_word_valid && $stable(codec_word); endproperty
  a_stall: assert property (p_stall) else $error("word dropped");
  property p_ovf; codec_overflow && !clear_codec_overflow |=> codec_overflow;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow lost");
endmodule : capture_front_end_chk
bind capture_front_end capture_front_end_chk capture_front_end_chk_inst (
  .ref_clk, .reset, .frame_irq, .frame_counter, .final_frame_irq_arm,
  .final_frame_irq_enable, .sync_mode_select, .frame_sync_in,
  .invert_frame_sync, .frame_sync_status, .soft_reset_bit, .codec_word_valid,
  .codec_word_ready, .codec_word, .codec_overflow, .clear_codec_overflow);

//--- tb/camera_model.sv
// behavioural camera: pixel clock, bytes, frame and line sync
`timescale 1ns/100ps
module camera_model (
  output logic       pclk,
  output logic [7:0] data,
  output logic       fsync,
  output logic       lvalid
);
  initial begin
    pclk = 1'b0;
    data = 8'h5a;
    fsync = 1'b0;
    lvalid = 1'b0;
  end
  always #3 pclk = ~pclk;
  // idle bus keeps moving so a stale byte never looks valid
  always @(posedge pclk) if (!lvalid) data <= ~data;
  task automatic put(input logic [7:0] b);
    @(negedge pclk);
    data = b;
    lvalid = 1'b1;
  endtask : put
  task automatic rest();
    @(negedge pclk);
    lvalid = 1'b0;
  endtask : rest
  task automatic vsync(input logic lvl);
    @(negedge pclk);
    fsync = lvl;
  endtask : vsync
endmodule : camera_model

//--- tb/tb_capture_front_end.sv
// self-checking bench for the capture front end
`timescale 1ns/100ps
module tb_capture_front_end;
  logic ref_clk = 1'b0, reset = 1'b1, mode = 1'b1, crdy = 1'b0, prdy = 1'b0;
  logic g = 1'b0, c = 1'b0, p = 1'b0, arm = 1'b0, srst = 1'b0, clr = 1'b0;
  logic pclk, fs, lv, cv, pv, irq, fss, fen, ovf, fst, bst;
  logic ifs = 1'b0, f4 = 1'b0;
  logic [7:0] pix;
  logic [1:0] fcnt, cnt = 2'h0;
  capture_pkg::bus_word_t cw;
  logic [33:0] expq[$];
  int n_fail = 0, cmp_count = 0, n_irq = 0, n_pw = 0;
  integer seed = 32'he93f3ae3;
  camera_model camera_model_inst (.pclk(pclk), .data(pix), .fsync(fs),
    .lvalid(lv));
  capture_front_end capture_front_end_inst (.ref_clk(ref_clk), .reset(reset),
    .cam_pixel_clock_in(pclk), .pixel_bus_in(pix), .frame_sync_in(fs),
    .line_valid_in(lv), .sync_mode_select(mode), .invert_pixel_clock(1'b0),
    .invert_frame_sync(ifs), .invert_line_sync(1'b0),
    .capture_enable_global(g), .capture_enable_codec_scaler(c),
    .capture_enable_preview_scaler(p), .codec_format_420(f4),
    .preview_rgb24(p), .final_frame_irq_arm(arm), .soft_reset_bit(srst),
    .clear_codec_overflow(clr), .codec_word_ready(crdy),
    .preview_word_ready(prdy), .codec_word_valid(cv), .codec_word(cw),
    .preview_word_valid(pv), .preview_word(), .frame_irq(irq),
    .frame_counter(fcnt), .frame_sync_status(fss),
    .final_frame_irq_enable(fen), .codec_overflow(ovf), .field_status(fst),
    .blanking_status(bst));
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) {crdy, prdy} <= #1 2'($random(seed));
  always @(posedge ref_clk) if (irq === 1'b1) n_irq++;
  always @(posedge ref_clk) n_pw += (pv & prdy) === 1'b1;
  always @(posedge ref_clk) if (cv === 1'b1 && crdy === 1'b1) begin
    if (expq.size() == 0) chk({cw.plane, cw.data}, 34'h3_ffff_ffff);
    else chk({cw.plane, cw.data}, expq.pop_front());
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic code(input logic [7:0] xy);
    camera_model_inst.put(8'hfe);
    camera_model_inst.put(8'h01);
    camera_model_inst.put(8'h02);
    camera_model_inst.put(xy);
  endtask : code
  task automatic frame(input logic [2:0] en, input logic fire);
    int n0;
    {g, c, p} = en;
    if (mode) camera_model_inst.vsync(!ifs);
    else code(8'he3);
    tick(8);
    if (!mode) chk({fst, bst}, 2'h3);
    chk(fss, 1'b1);
    n0 = n_irq;
    if (mode) camera_model_inst.vsync(ifs);
    else begin
      code(8'h8e);
      code(8'h9d);
    end
    tick(10);
    if (!mode) chk({fst, bst}, 2'h0);
    chk(n_irq - n0, fire);
    cnt = cnt + fire;
    chk(fcnt, cnt);
    $display("frame done en=%b cnt=%0d", en, cnt);
  endtask : frame
  task automatic line(input logic cod);
    logic [7:0] b[16];
    foreach (b[i]) b[i] = 8'h10 + 8'($random(seed) & 32'h7f);
    if (cod) begin
      expq.push_back({2'h0, b[6], b[4], b[2], b[0]});
      if (!f4) expq.push_back({2'h1, b[13], b[9], b[5], b[1]});
      expq.push_back({2'h0, b[14], b[12], b[10], b[8]});
      if (!f4) expq.push_back({2'h2, b[15], b[11], b[7], b[3]});
    end
    if (!mode) code(8'h80);
    foreach (b[i]) camera_model_inst.put(b[i]);
    if (!mode) code(8'h9d);
    camera_model_inst.rest();
    tick(60);
  endtask : line
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
  initial begin
    tick(20);
    reset = 1'b0;
    tick(4);
    frame(3'b110, 1'b1);
    line(1'b1);
    frame(3'b101, 1'b1);
    line(1'b0);
    chk(ovf, 1'b1);
    chk(n_pw, 8);
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    cnt = 2'h0;
    tick(3);
    chk({ovf, fcnt}, 3'h4);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    arm = 1'b1;
    tick(1);
    arm = 1'b0;
    tick(1);
    chk({ovf, fen}, 2'h1);
    frame(3'b110, 1'b1);
    ifs = 1'b1;
    frame(3'b000, 1'b1);
    chk(fen, 1'b0);
    frame(3'b000, 1'b0);
    mode = 1'b0;
    f4 = 1'b1;
    frame(3'b110, 1'b1);
    line(1'b1);
    chk(expq.size(), 34'h0);
    close_out();
  end
endmodule : tb_capture_front_end
